// File: pkg/bgc_pkg.sv
package bgc_pkg;

    // register port
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CLOCK_RECOVERY_CONFIG = 6'h1A;
    localparam logic [ADDR_W-1:0] ADDR_GAIN_CONTROL_CONFIG_TWO = 6'h1B;
    localparam logic [DATA_W-1:0] RST_CLOCK_RECOVERY_CONFIG = 8'h6C;
    localparam logic [DATA_W-1:0] RST_GAIN_CONTROL_CONFIG_TWO = 8'h03;
    localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 8'h00;

    // clock_recovery_config fields
    localparam int PRE_KI_HI = 7;
    localparam int PRE_KI_LO = 6;
    localparam int PRE_KP_HI = 5;
    localparam int PRE_KP_LO = 4;
    localparam int POST_KI_BIT = 3;
    localparam int POST_KP_BIT = 2;
    localparam int RATE_LIM_HI = 1;
    localparam int RATE_LIM_LO = 0;

    // gain_control_config_two fields
    localparam int DAMP_CAP_HI = 7;
    localparam int DAMP_CAP_LO = 6;
    localparam int FRONT_CAP_HI = 5;
    localparam int FRONT_CAP_LO = 3;
    localparam int AMP_TGT_HI = 2;
    localparam int AMP_TGT_LO = 0;

    // gain encodings: integral in half base units, proportional in base units
    localparam int KI_W = 4;
    localparam int KP_W = 3;
    localparam logic [KI_W-1:0] KI_HALF_OF_BASE = 4'h1;
    localparam logic [KP_W-1:0] KP_BASE = 3'h1;
    localparam logic [2:0] MULT_OFFSET = 3'h1;

    // rate offset limit in steps of 3.125 percent
    localparam int RATE_W = 3;
    localparam logic [RATE_W-1:0] RATE_LIMIT_TBL [4] = '{3'h0, 3'h1, 3'h2, 3'h4};

    // front amplifier gain cut in tenths of a dB
    localparam int FRONT_W = 8;
    localparam logic [FRONT_W-1:0] FRONT_CUT_TBL [8] =
        '{8'h00, 8'h1A, 8'h3D, 8'h4A, 8'h5C, 8'h73, 8'h92, 8'hAB};

    // channel filter amplitude target in dB
    localparam int TGT_W = 6;
    localparam logic [TGT_W-1:0] AMP_TARGET_TBL [8] =
        '{6'h18, 6'h1B, 6'h1E, 6'h21, 6'h24, 6'h26, 6'h28, 6'h2A};

    // sync tracking states
    typedef enum logic {
        BGC_HUNT,
        BGC_LOCKED
    } bgc_sync_t;

    // pre-sync code 0..3 to gain multiple 1..4
    function automatic logic [2:0] bgc_mult(input logic [1:0] code);
        return {1'b0, code} + MULT_OFFSET;
    endfunction

endpackage

// File: hw/bgc_gain_decode.sv
`timescale 1ns/1ps
// selects clock recovery loop gains for the current sync phase
module bgc_gain_decode (
    input wire logic [1:0] i_pre_ki, // pre-sync integral code
    input wire logic [1:0] i_pre_kp, // pre-sync proportional code
    input wire logic i_post_ki, // post-sync integral select
    input wire logic i_post_kp, // post-sync proportional select
    input wire logic i_post_active, // sync word seen
    output logic [bgc_pkg::KI_W-1:0] o_ki_half, // integral gain, half base units
    output logic [bgc_pkg::KP_W-1:0] o_kp // proportional gain, base units
);
    import bgc_pkg::*;

    logic [2:0] ki_mult;
    logic [2:0] kp_mult;
    logic [KI_W-1:0] ki_pre_half;
    logic use_ki_half;
    logic use_kp_base;

    // multiples of the base gains before sync
    assign ki_mult = bgc_mult(i_pre_ki);
    assign kp_mult = bgc_mult(i_pre_kp);
    assign ki_pre_half = {ki_mult, 1'b0};

    // post-sync override only once sync is active
    assign use_ki_half = i_post_active & i_post_ki;
    assign use_kp_base = i_post_active & i_post_kp;
    assign o_ki_half = use_ki_half ? KI_HALF_OF_BASE : ki_pre_half;
    assign o_kp = use_kp_base ? KP_BASE : kp_mult;

endmodule

// File: hw/bgc_config_regs.sv
`timescale 1ns/1ps
module bgc_config_regs #(
    parameter logic [2:0] DAMP_TOP_STEP = 3'h7 // highest digital amp gain step
) (
    input wire logic i_mclk, // system clock
    input wire logic i_rst_n, // synchronous reset, active low
    input wire logic i_ce, // clock enable, freezes state when low
    input wire logic [bgc_pkg::ADDR_W-1:0] i_reg_addr, // register address
    input wire logic i_reg_wr, // write strobe
    input wire logic [bgc_pkg::DATA_W-1:0] i_reg_wdata, // write data
    input wire logic i_reg_rd, // read strobe
    input wire logic i_sync_det, // sync word detected pulse
    input wire logic i_rx_restart, // reception restart pulse
    output logic [bgc_pkg::DATA_W-1:0] o_reg_rdata, // read data
    output logic o_reg_rvalid, // read data valid
    output logic o_post_sync_active, // post-sync gains in use
    output logic [bgc_pkg::KI_W-1:0] o_ki_half, // integral gain, half base units
    output logic [bgc_pkg::KP_W-1:0] o_kp, // proportional gain, base units
    output logic [bgc_pkg::RATE_W-1:0] o_rate_limit, // rate limit, 3.125 pct steps
    output logic [2:0] o_damp_max_step, // highest usable digital amp step
    output logic [bgc_pkg::FRONT_W-1:0] o_front_cut, // front amp cut, 0.1 dB
    output logic [bgc_pkg::TGT_W-1:0] o_amp_target // amplitude target, dB
);
    import bgc_pkg::*;

    logic [DATA_W-1:0] crcfg_reg;
    logic [DATA_W-1:0] crcfg_next;
    logic [DATA_W-1:0] gc2_reg;
    logic [DATA_W-1:0] gc2_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic rvalid_reg;
    bgc_sync_t sync_reg;
    bgc_sync_t sync_next;

    // address decode
    wire hit_crcfg = (i_reg_addr == ADDR_CLOCK_RECOVERY_CONFIG);
    wire hit_gc2 = (i_reg_addr == ADDR_GAIN_CONTROL_CONFIG_TWO);
    wire wr_crcfg = i_reg_wr & hit_crcfg;
    wire wr_gc2 = i_reg_wr & hit_gc2;

    // register next values
    assign crcfg_next = wr_crcfg ? i_reg_wdata : crcfg_reg;
    assign gc2_next = wr_gc2 ? i_reg_wdata : gc2_reg;

    // read mux, unmapped addresses return zero
    assign rdata_next = hit_crcfg ? crcfg_reg :
                        hit_gc2 ? gc2_reg : RDATA_UNMAPPED;

    // configuration storage
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            crcfg_reg <= RST_CLOCK_RECOVERY_CONFIG;
            gc2_reg <= RST_GAIN_CONTROL_CONFIG_TWO;
        end else if (i_ce) begin
            crcfg_reg <= crcfg_next;
            gc2_reg <= gc2_next;
        end
    end

    // registered read answer
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rdata_reg <= RDATA_UNMAPPED;
            rvalid_reg <= 1'b0;
        end else if (i_ce) begin
            rvalid_reg <= i_reg_rd;
            if (i_reg_rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_reg_rvalid = rvalid_reg;

    // sync tracking, a sync flag beats a restart in the same cycle
    always_comb begin
        sync_next = sync_reg;
        case (sync_reg)
            BGC_HUNT: begin
                if (i_sync_det) begin
                    sync_next = BGC_LOCKED;
                end
            end
            BGC_LOCKED: begin
                if (i_rx_restart && !i_sync_det) begin
                    sync_next = BGC_HUNT;
                end
            end
            default: begin
                sync_next = BGC_HUNT;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sync_reg <= BGC_HUNT;
        end else if (i_ce) begin
            sync_reg <= sync_next;
        end
    end

    // post-sync gains apply already in the flag cycle
    assign o_post_sync_active = (sync_reg == BGC_LOCKED) | (i_sync_det & i_ce);

    // clock recovery gain selection
    bgc_gain_decode u_gain (
        .i_pre_ki(crcfg_reg[PRE_KI_HI:PRE_KI_LO]),
        .i_pre_kp(crcfg_reg[PRE_KP_HI:PRE_KP_LO]),
        .i_post_ki(crcfg_reg[POST_KI_BIT]),
        .i_post_kp(crcfg_reg[POST_KP_BIT]),
        .i_post_active(o_post_sync_active),
        .o_ki_half(o_ki_half),
        .o_kp(o_kp)
    );

    // field decodes for the demodulator and gain controller
    wire [1:0] rate_code = crcfg_reg[RATE_LIM_HI:RATE_LIM_LO];
    wire [1:0] damp_code = gc2_reg[DAMP_CAP_HI:DAMP_CAP_LO];
    wire [2:0] front_code = gc2_reg[FRONT_CAP_HI:FRONT_CAP_LO];
    wire [2:0] tgt_code = gc2_reg[AMP_TGT_HI:AMP_TGT_LO];
    assign o_rate_limit = RATE_LIMIT_TBL[rate_code];
    assign o_damp_max_step = DAMP_TOP_STEP - {1'b0, damp_code};
    assign o_front_cut = FRONT_CUT_TBL[front_code];
    assign o_amp_target = AMP_TARGET_TBL[tgt_code];

    // ---- checks ----
    wire [1:0] pre_ki_code = crcfg_reg[PRE_KI_HI:PRE_KI_LO];
    wire [1:0] pre_kp_code = crcfg_reg[PRE_KP_HI:PRE_KP_LO];

    sequence s_write_crcfg;
        i_ce && i_reg_wr && i_reg_addr == ADDR_CLOCK_RECOVERY_CONFIG;
    endsequence

    sequence s_write_gc2;
        i_ce && i_reg_wr && i_reg_addr == ADDR_GAIN_CONTROL_CONFIG_TWO;
    endsequence

    property p_presync_ki;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !o_post_sync_active |-> o_ki_half == KI_W'(2 * (pre_ki_code + 1));
    endproperty
    a_presync_ki: assert property (p_presync_ki)
        else $error("pre-sync integral gain wrong");

    property p_presync_kp;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_write_crcfg ##1 !o_post_sync_active
            |-> o_kp == KP_W'(pre_kp_code + 1)
                && pre_kp_code == $past(i_reg_wdata[PRE_KP_HI:PRE_KP_LO]);
    endproperty
    a_presync_kp: assert property (p_presync_kp)
        else $error("pre-sync proportional gain wrong");

    property p_postsync_ki;
        @(posedge i_mclk) disable iff (!i_rst_n)
        o_post_sync_active |->
            (crcfg_reg[POST_KI_BIT] ? o_ki_half == KI_HALF_OF_BASE
                : o_ki_half == KI_W'(2 * (pre_ki_code + 1)));
    endproperty
    a_postsync_ki: assert property (p_postsync_ki)
        else $error("post-sync integral gain wrong");

    property p_postsync_kp;
        @(posedge i_mclk) disable iff (!i_rst_n)
        o_post_sync_active |->
            (crcfg_reg[POST_KP_BIT] ? o_kp == KP_BASE : o_kp == KP_W'(pre_kp_code + 1));
    endproperty
    a_postsync_kp: assert property (p_postsync_kp)
        else $error("post-sync proportional gain wrong");

    property p_rate_limit;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_write_crcfg ##1 1'b1 |->
            o_rate_limit == ($past(i_reg_wdata[RATE_LIM_HI:RATE_LIM_LO]) == 2'h3 ? 3'h4
                : {1'b0, $past(i_reg_wdata[RATE_LIM_HI:RATE_LIM_LO])});
    endproperty
    a_rate_limit: assert property (p_rate_limit)
        else $error("rate limit decode wrong");

    property p_damp_cap;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_write_gc2 ##1 1'b1 |->
            o_damp_max_step == 3'(DAMP_TOP_STEP - $past(i_reg_wdata[DAMP_CAP_HI:DAMP_CAP_LO]));
    endproperty
    a_damp_cap: assert property (p_damp_cap)
        else $error("digital amp cap wrong");

    property p_front_cap;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (front_code == 3'h0 |-> o_front_cut == 8'h00) and
        (front_code == 3'h7 |-> o_front_cut == 8'hAB);
    endproperty
    a_front_cap: assert property (p_front_cap)
        else $error("front amp cap wrong");

    property p_amp_target;
        @(posedge i_mclk)
        $rose(i_rst_n) |-> o_amp_target == 6'h21 && o_front_cut == 8'h00 && o_damp_max_step == DAMP_TOP_STEP;
    endproperty
    a_amp_target: assert property (p_amp_target)
        else $error("gain control reset values wrong");

    property p_amp_target_top;
        @(posedge i_mclk) disable iff (!i_rst_n)
        tgt_code == 3'h7 |-> o_amp_target == 6'h2A;
    endproperty
    a_amp_target_top: assert property (p_amp_target_top)
        else $error("amplitude target top wrong");

    sequence s_sync_seen;
        i_ce && i_sync_det;
    endsequence

    property p_sync_switch;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_sync_seen |-> o_post_sync_active ##1 o_post_sync_active;
    endproperty
    a_sync_switch: assert property (p_sync_switch)
        else $error("post-sync gains not taken on sync");

    property p_restart_return;
        @(posedge i_mclk) disable iff (!i_rst_n)
        i_ce && i_rx_restart && !i_sync_det ##1 !i_sync_det |-> !o_post_sync_active;
    endproperty
    a_restart_return: assert property (p_restart_return)
        else $error("pre-sync gains not restored on restart");

endmodule

// File: testbench/bgc_host_model.sv
`timescale 1ns/1ps
// host side of the register port, one request held over its taken edge
module bgc_host_model (
    input wire logic i_mclk, // system clock
    input wire logic [bgc_pkg::DATA_W-1:0] i_rdata, // read data
    input wire logic i_rvalid, // read data valid
    output logic [bgc_pkg::ADDR_W-1:0] o_addr, // register address
    output logic o_wr, // write strobe
    output logic [bgc_pkg::DATA_W-1:0] o_wdata, // write data
    output logic o_rd // read strobe
);
    import bgc_pkg::*;
    // idle port from time zero
    initial begin
        o_addr = '0;
        o_wr = 1'b0;
        o_wdata = '0;
        o_rd = 1'b0;
    end
    // one write; released data flips so stale values never look valid
    task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
    // one read; the answer stands in the cycle after the taken edge
    task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                            output logic v);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
        v = i_rvalid;
    endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import bgc_pkg::*;
    logic i_mclk;
    logic i_rst_n = 1'b0;
    logic i_ce = 1'b1;
    logic i_sync_det = 1'b0;
    logic i_rx_restart = 1'b0;
    logic [ADDR_W-1:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_rvalid;
    logic post_active;
    logic [KI_W-1:0] ki_half;
    logic [KP_W-1:0] kp;
    logic [RATE_W-1:0] rate_limit;
    logic [2:0] damp_max;
    logic [FRONT_W-1:0] front_cut;
    logic [TGT_W-1:0] amp_target;
    logic [7:0] rd_data;
    logic rd_valid;
    int fails = 0;
    int tests_run = 0;

    bgc_host_model host (.i_mclk(i_mclk), .i_rdata(reg_rdata), .i_rvalid(reg_rvalid),
        .o_addr(reg_addr), .o_wr(reg_wr), .o_wdata(reg_wdata), .o_rd(reg_rd));
    bgc_config_regs #(.DAMP_TOP_STEP(3'h7)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_ce(i_ce), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata),
        .i_reg_rd(reg_rd), .i_sync_det(i_sync_det), .i_rx_restart(i_rx_restart),
        .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid), .o_post_sync_active(post_active),
        .o_ki_half(ki_half), .o_kp(kp), .o_rate_limit(rate_limit), .o_damp_max_step(damp_max),
        .o_front_cut(front_cut), .o_amp_target(amp_target));

    // compare one value and count it
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // read a register and judge both valid and data
    task automatic read_chk(input string what, input logic [5:0] a, input logic [7:0] exp);
        host.read_reg(a, rd_data, rd_valid);
        check({what, " valid"}, 8'h01, {7'h00, rd_valid});
        check(what, exp, rd_data);
        // the read answer stands for one cycle only
        @(posedge i_mclk);
        #1;
        check({what, " valid end"}, 8'h00, {7'h00, reg_rvalid});
    endtask
    // readback and decoded outputs straight after reset
    task automatic scn_reset;
        read_chk("crc reset", ADDR_CLOCK_RECOVERY_CONFIG, 8'h6C);
        read_chk("gcc reset", ADDR_GAIN_CONTROL_CONFIG_TWO, 8'h03);
        check("ki reset", 8'h04, 8'(ki_half));
        check("kp reset", 8'h03, 8'(kp));
        check("rate reset", 8'h00, 8'(rate_limit));
        check("damp reset", 8'h07, 8'(damp_max));
        check("front reset", 8'h00, 8'(front_cut));
        check("target reset", 8'h21, 8'(amp_target));
    endtask
    // every code of the amplifier caps and the amplitude target
    task automatic scn_gain_codes;
        logic [7:0] front [8] = '{8'h00, 8'h1A, 8'h3D, 8'h4A, 8'h5C, 8'h73, 8'h92, 8'hAB};
        logic [7:0] tgt [8] = '{8'h18, 8'h1B, 8'h1E, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2A};
        for (int c = 0; c < 8; c++) begin
            host.write_reg(ADDR_GAIN_CONTROL_CONFIG_TWO, {c[1:0], c[2:0], c[2:0]});
            #1;
            check("damp cap", 8'h07 - 8'(c[1:0]), 8'(damp_max));
            check("front cap", front[c], 8'(front_cut));
            check("amp target", tgt[c], 8'(amp_target));
        end
        read_chk("gcc readback", ADDR_GAIN_CONTROL_CONFIG_TWO, 8'hFF);
    endtask
    // pre-sync gains and rate limit; post bits must not act before sync
    task automatic scn_presync_codes;
        logic [7:0] rate [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
        for (int c = 0; c < 4; c++) begin
            host.write_reg(ADDR_CLOCK_RECOVERY_CONFIG, {c[1:0], c[1:0], c[0], c[0], c[1:0]});
            #1;
            check("pre ki", 8'(2 * (c + 1)), 8'(ki_half));
            check("pre kp", 8'(c + 1), 8'(kp));
            check("rate limit", rate[c], 8'(rate_limit));
        end
        read_chk("crc readback", ADDR_CLOCK_RECOVERY_CONFIG, 8'hFF);
    endtask
    // gains follow sync detection and reception restart
    task automatic scn_sync;
        host.write_reg(ADDR_CLOCK_RECOVERY_CONFIG, 8'hF0);
        i_sync_det <= 1'b1;
        #1;
        check("post on sync", 8'h01, 8'(post_active));
        check("post ki kept", 8'h08, 8'(ki_half));
        check("post kp kept", 8'h04, 8'(kp));
        @(posedge i_mclk);
        i_sync_det <= 1'b0;
        host.write_reg(ADDR_CLOCK_RECOVERY_CONFIG, 8'hFC);
        i_rx_restart <= 1'b1;
        #1;
        check("post ki half", 8'h01, 8'(ki_half));
        check("post kp base", 8'h01, 8'(kp));
        @(posedge i_mclk);
        i_rx_restart <= 1'b0;
        #1;
        check("post after restart", 8'h00, 8'(post_active));
        check("ki after restart", 8'h08, 8'(ki_half));
        @(posedge i_mclk);
        i_sync_det <= 1'b1;
        i_rx_restart <= 1'b1;
        // first edge locks, second edge meets both flags while locked
        @(posedge i_mclk);
        @(posedge i_mclk);
        i_sync_det <= 1'b0;
        i_rx_restart <= 1'b0;
        #1;
        check("sync beats restart", 8'h01, 8'(post_active));
    endtask
    // stray and clock-gated requests leave the registers alone
    task automatic scn_refused;
        host.write_reg(6'h1C, 8'h00);
        read_chk("unmapped read", 6'h1C, 8'h00);
        read_chk("crc after stray", ADDR_CLOCK_RECOVERY_CONFIG, 8'hFC);
        @(posedge i_mclk);
        i_ce <= 1'b0;
        host.write_reg(ADDR_GAIN_CONTROL_CONFIG_TWO, 8'h00);
        i_ce <= 1'b1;
        read_chk("gcc gated", ADDR_GAIN_CONTROL_CONFIG_TWO, 8'hFF);
    endtask
    // verdict and end of run
    task automatic conclude;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // free-running system clock
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    // watchdog cuts a hung run short
    initial begin
        repeat (20000) @(posedge i_mclk);
        $display("FAIL watchdog expected finish seen timeout");
        fails++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        scn_reset();
        scn_gain_codes();
        scn_presync_codes();
        scn_sync();
        scn_refused();
        conclude();
    end
endmodule
